// ### logic/access_pacer.sv
`timescale 1ns/1ps
`include "transfer_controller_cfg.svh"
module access_pacer
  import transfer_controller_pkg::*;
#(
  parameter logic [31:0] IO2_LO = 32'hFFFF_8000,
  parameter logic [31:0] IO2_HI = 32'hFFFF_85FF,
  parameter logic [31:0] IO3_LO = 32'hFFFF_8600,
  parameter logic [31:0] IO3_HI = 32'hFFFF_87FF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic active,
  input wire logic [31:0] addr,
  input wire logic long_unit,
  input wire logic done,
  output logic open
);
  import transfer_controller_pkg::*;
  logic [2:0] waited;

  // ----------------------------------------
  // State count per access
  // ----------------------------------------
  // Slow peripherals hold the request back; a longword there is two bus cycles.
  wire is_io3 = (addr >= IO3_LO) && (addr <= IO3_HI);
  wire is_io2 = (addr >= IO2_LO) && (addr <= IO2_HI);
  wire [2:0] per_cycle = is_io3 ? `STATES_IO3 : is_io2 ? `STATES_IO2 : `STATES_FAST;
  wire [2:0] need = (long_unit && (is_io2 || is_io3)) ? 3'(per_cycle << 1) : per_cycle;
  assign open = active && (waited >= need - 3'h1);

  // Counter restarts for every access so back-to-back accesses pay in full.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      waited <= 3'h0;
    else if (done || !active)
      waited <= 3'h0;
    else if (!open)
      waited <= waited + 3'h1;
  end
endmodule

// ### logic/addr_stepper.sv
`timescale 1ns/1ps
`include "transfer_controller_cfg.svh"
module addr_stepper
  import transfer_controller_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic [1:0] step,
  input wire logic [1:0] size,
  output logic [31:0] next_addr
);
  // ----------------------------------------
  // Step by one unit
  // ----------------------------------------
  // Step code 10 increments, 11 decrements, anything else holds the address.
  wire [31:0] unit = (size == SIZE_BYTE) ? 32'h0000_0001 :
                     (size == SIZE_WORD) ? 32'h0000_0002 : 32'h0000_0004;
  assign next_addr = (step == 2'h2) ? addr + unit :
                     (step == 2'h3) ? addr - unit : addr;
endmodule

// ### logic/transfer_controller.sv
`timescale 1ns/1ps
`include "transfer_controller_cfg.svh"
module transfer_controller
  import transfer_controller_pkg::*;
#(
  parameter int SRC_W = 6
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic act_valid,
  input wire logic [SRC_W-1:0] act_source,
  output logic act_ready,
  output transfer_controller_pkg::mem_req_t mem_req,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  output logic irq_req,
  output logic xfer_done
);
  import transfer_controller_pkg::*;

  state_t state;
  logic [1:0] idx;
  logic [31:0] vec_addr;
  logic [31:0] start_addr;
  logic [15:0] mode;
  logic [15:0] count;
  logic [31:0] word1;
  logic [31:0] src;
  logic [31:0] dst;
  logic [31:0] src_init;
  logic [31:0] dst_init;
  logic [16:0] blk_left;
  logic [31:0] data_buf;
  logic [15:0] info_base;
  logic [7:0] sw_vec;
  logic sw_pending;
  logic [15:0] last_count;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic pace_open;
  logic [31:0] src_step;
  logic [31:0] dst_step;
  logic hw_take;
  logic sw_take;

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  // Zero wait states and always OKAY; unmapped reads return zero.
  wire ahb_take = hsel && htrans[1] && hready;
  wire [31:0] status_word = {last_count, 14'h0, sw_pending, state != ST_IDLE};
  wire [31:0] rd_mux = (haddr == `REG_INFO_BASE) ? {16'h0, info_base} :
                       (haddr == `REG_SW_CTRL) ? {23'h0, sw_pending, sw_vec} :
                       (haddr == `REG_STATUS) ? status_word : 32'h0;
  wire sw_write = wr_pend && (wr_addr == `REG_SW_CTRL);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase is held one cycle so the write lands in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend <= ahb_take && hwrite;
      if (ahb_take)
        wr_addr <= haddr;
      if (ahb_take && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // Software settings; a start written while one is accepted still counts.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      info_base <= `INFO_BASE_RESET;
      sw_vec <= 8'h00;
      sw_pending <= 1'b0;
    end
    else
    begin
      if (wr_pend && (wr_addr == `REG_INFO_BASE))
        info_base <= hwdata[15:0];
      if (sw_write)
        sw_vec <= hwdata[7:0];
      if (sw_write && hwdata[`SW_START_BIT])
        sw_pending <= 1'b1;
      else if (sw_take)
        sw_pending <= 1'b0;
    end
  end

  // ----------------------------------------
  // Activation and field decode
  // ----------------------------------------
  // Hardware sources win over a pending software start.
  assign hw_take = (state == ST_IDLE) && act_valid;
  assign sw_take = (state == ST_IDLE) && !act_valid && sw_pending;
  assign act_ready = hw_take;
  wire [31:0] hw_vec = `VEC_BASE + {{(31-SRC_W){1'b0}}, act_source, 1'b0};
  wire [31:0] sw_vec_addr = `VEC_BASE + {24'h0, sw_vec};

  wire [1:0] md = mode[`MW_MD];
  wire [1:0] sz = mode[`MW_SZ];
  wire area_select_bit = mode[`MW_DTS];
  wire chain_enable_bit = mode[`MW_CHAIN_ENABLE_BIT];
  wire per_transfer_irq_select = mode[`MW_PER_TRANSFER_IRQ_SELECT];
  wire is_repeat = (md == MODE_REPEAT);
  wire is_block = (md == MODE_BLOCK);

  // Zero length means the full 65536 units.
  wire [16:0] blk_len = is_block ? {word1[15:0] == 16'h0, word1[15:0]} : 17'h1;

  // ----------------------------------------
  // Write-back values
  // ----------------------------------------
  // The repeat wrap point is the low byte reaching one; count 0 behaves as 256.
  wire rpt_wrap = is_repeat && (count[7:0] == 8'h01);
  wire [15:0] count_wb = !is_repeat ? count - 16'h1 :
                         rpt_wrap ? {count[15:8], count[15:8]} :
                         {count[15:8], count[7:0] - 8'h01};
  // Repeat restores from the initial address word, block from the fetched value.
  wire [31:0] src_wb = (rpt_wrap && area_select_bit) ? word1 :
                       (is_block && area_select_bit) ? src_init : src;
  wire [31:0] dst_wb = (rpt_wrap && !area_select_bit) ? word1 :
                       (is_block && !area_select_bit) ? dst_init : dst;
  // Repeat mode only interrupts per transfer when asked to.
  wire irq_cond = per_transfer_irq_select || (!is_repeat && (count == 16'h0001));

  // ----------------------------------------
  // Address steppers
  // ----------------------------------------
  addr_stepper u_src_step
  (
    .addr(src),
    .step(mode[`MW_SM]),
    .size(sz),
    .next_addr(src_step)
  );

  addr_stepper u_dst_step
  (
    .addr(dst),
    .step(mode[`MW_DM]),
    .size(sz),
    .next_addr(dst_step)
  );

  // ----------------------------------------
  // Memory request
  // ----------------------------------------
  // Write-back skips the second layout word, which is never written.
  wire [31:0] wb_off = (idx == 2'h0) ? 32'h0 : {28'h0, 2'(idx + 2'h1), 2'h0};
  wire [31:0] prd_addr = start_addr + {28'h0, idx, 2'h0};
  wire in_access = (state != ST_IDLE);
  wire [31:0] acc_addr = (state == ST_VEC) ? vec_addr :
                         (state == ST_PRD) ? prd_addr :
                         (state == ST_DRD) ? src :
                         (state == ST_DWR) ? dst : start_addr + wb_off;
  wire [1:0] acc_size = (state == ST_VEC) ? SIZE_WORD :
                        ((state == ST_DRD) || (state == ST_DWR)) ? sz : SIZE_LONG;
  wire acc_write = (state == ST_DWR) || (state == ST_PWB);
  wire [31:0] acc_wdata = (state == ST_DWR) ? data_buf :
                          (idx == 2'h0) ? {mode, count_wb} :
                          (idx == 2'h1) ? src_wb : dst_wb;
  wire acc_done = in_access && pace_open && mem_ready;

  assign mem_req.valid = in_access && pace_open;
  assign mem_req.write = acc_write;
  assign mem_req.size = acc_size;
  assign mem_req.addr = acc_addr;
  assign mem_req.wdata = acc_wdata;

  access_pacer u_pacer
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .active(in_access),
    .addr(acc_addr),
    .long_unit(acc_size == SIZE_LONG),
    .done(acc_done),
    .open(pace_open)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Vector, four parameter reads, data pairs, three write-backs, then chain or stop.
  wire last_unit = (blk_left == 17'h1);
  wire last_wb = (state == ST_PWB) && (idx == 2'h2) && acc_done;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      idx <= 2'h0;
      vec_addr <= 32'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          idx <= 2'h0;
          if (hw_take || sw_take)
          begin
            vec_addr <= hw_take ? hw_vec : sw_vec_addr;
            state <= ST_VEC;
          end
        end
        ST_VEC:
          if (acc_done)
            state <= ST_PRD;
        ST_PRD:
          if (acc_done)
          begin
            idx <= idx + 2'h1;
            if (idx == 2'h3)
              state <= ST_DRD;
          end
        ST_DRD:
          if (acc_done)
            state <= ST_DWR;
        ST_DWR:
          if (acc_done)
            state <= last_unit ? ST_PWB : ST_DRD;
        ST_PWB:
          if (acc_done)
          begin
            idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
            if (idx == 2'h2)
              state <= chain_enable_bit ? ST_PRD : ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Parameter and data registers
  // ----------------------------------------
  // Start address comes from the base register and the vector entry.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_addr <= 32'h0;
      mode <= 16'h0;
      count <= 16'h0;
      word1 <= 32'h0;
    end
    else if (acc_done && (state == ST_VEC))
      start_addr <= {info_base, mem_rdata[15:0]};
    else if (last_wb && chain_enable_bit)
      start_addr <= start_addr + `CHAIN_STRIDE;
    else if (acc_done && (state == ST_PRD) && (idx == 2'h0))
    begin
      mode <= mem_rdata[31:16];
      count <= mem_rdata[15:0];
    end
    else if (acc_done && (state == ST_PRD) && (idx == 2'h1))
      word1 <= mem_rdata;
  end

  // Working addresses step after every unit written.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src <= 32'h0;
      dst <= 32'h0;
      src_init <= 32'h0;
      dst_init <= 32'h0;
      blk_left <= 17'h0;
      data_buf <= 32'h0;
    end
    else if (acc_done && (state == ST_PRD) && (idx == 2'h2))
    begin
      src <= mem_rdata;
      src_init <= mem_rdata;
    end
    else if (acc_done && (state == ST_PRD) && (idx == 2'h3))
    begin
      dst <= mem_rdata;
      dst_init <= mem_rdata;
      blk_left <= blk_len;
    end
    else if (acc_done && (state == ST_DRD))
      data_buf <= mem_rdata;
    else if (acc_done && (state == ST_DWR))
    begin
      src <= src_step;
      dst <= dst_step;
      blk_left <= blk_left - 17'h1;
    end
  end

  // ----------------------------------------
  // Completion outputs
  // ----------------------------------------
  // At most one interrupt pulse per parameter block; the done pulse marks the end of the chain.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req <= 1'b0;
      xfer_done <= 1'b0;
      last_count <= 16'h0;
    end
    else
    begin
      irq_req <= last_wb && irq_cond;
      xfer_done <= last_wb && !chain_enable_bit;
      if (last_wb)
        last_count <= count_wb;
    end
  end
endmodule

// ### logic/transfer_controller_cfg.svh
`ifndef TRANSFER_CONTROLLER_CFG_SVH
`define TRANSFER_CONTROLLER_CFG_SVH
// Contract
// - Parameter block start is base register upper half plus vector entry lower half.
// - Normal layout: mode, count, four ignored bytes, source, destination.
// - Repeat layout: mode, count, initial address, source, destination.
// - Block layout: mode, count, two ignored bytes, block length, source, destination.
// - Normal mode moves one unit per activation; count 1 to 65536.
// - Normal write-back: mode unchanged, count minus one, both addresses stepped.
// - Normal mode requests CPU interrupt after the transfer made with count one.
// - Repeat count 1 to 256; at exhaustion low reloads from high, area restarts.
// - Area select 0 restores destination, 1 restores source; other address steps.
// - Repeat mode with per-transfer select clear never requests an interrupt.
// - Block mode moves one block of 1 to 65536 units; area address restored.
// - Block count 1 to 65536; interrupt after the block moved with count one.
// - Block write-back: count minus one, length not written, area address restored.
// - Parameter read takes four accesses, write-back three, in every mode.
// - Block mode does as many data reads and writes as the block length.
// - Activation time is vector read plus all parameter and data accesses plus internal.
// - Peripheral accesses take two or three states; a longword costs two bus cycles.
// - Each vector table entry is two bytes holding the start address lower half.
// - Per-transfer select set requests a CPU interrupt after every transfer.

// ----------------------------------------
// Address map and memory layout
// ----------------------------------------
`define VEC_BASE 32'h0000_0400
`define CHAIN_STRIDE 32'h0000_0010
`define REG_INFO_BASE 32'h0000_0000
`define REG_SW_CTRL 32'h0000_0004
`define REG_STATUS 32'h0000_0008
`define SW_START_BIT 8
`define INFO_BASE_RESET 16'h0000

// ----------------------------------------
// Mode word fields
// ----------------------------------------
`define MW_SM 15:14
`define MW_DM 13:12
`define MW_MD 11:10
`define MW_SZ 9:8
`define MW_DTS 7
`define MW_CHAIN_ENABLE_BIT 6
`define MW_PER_TRANSFER_IRQ_SELECT 5

// ----------------------------------------
// Access state counts
// ----------------------------------------
`define STATES_FAST 3'h1
`define STATES_IO2 3'h2
`define STATES_IO3 3'h3
`endif

// ### logic/transfer_controller_pkg.sv
package transfer_controller_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_VEC = 3'h1,
    ST_PRD = 3'h2,
    ST_DRD = 3'h3,
    ST_DWR = 3'h4,
    ST_PWB = 3'h5
  } state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_REPEAT = 2'h1,
    MODE_BLOCK = 2'h2
  } xfer_mode_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } unit_size_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
endpackage

// ### testbench/bus_memory.sv
`timescale 1ns/1ps
module bus_memory
  import transfer_controller_pkg::*;
(
  input wire logic hclk,
  input wire logic slow,
  input wire transfer_controller_pkg::mem_req_t mem_req,
  output logic mem_ready,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem [logic [31:0]];
  logic tick = 1'b0;
  int n_rd = 0;
  int n_wr = 0;
  // Units sit high byte first and come back right-aligned.
  function automatic logic [31:0] get(input logic [31:0] a, input int nb);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < nb; i++)
      v = {v[23:0], mem.exists(a + i) ? mem[a + i] : 8'h5A};
    return v;
  endfunction
  function automatic void put(input logic [31:0] a, input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++)
      mem[a + i] = v[8 * (nb - 1 - i) +: 8];
  endfunction
  // A slow memory answers every second cycle; between answers the data is inverted.
  assign mem_ready = !slow || tick;
  always @*
    mem_rdata = mem_ready ? get(mem_req.addr, 1 << mem_req.size) : ~get(mem_req.addr, 1 << mem_req.size);
  // Completed accesses are counted so totals per activation can be checked.
  always @(posedge hclk)
  begin
    tick <= slow && !tick;
    if (mem_req.valid && mem_ready && mem_req.write)
    begin
      put(mem_req.addr, mem_req.wdata, 1 << mem_req.size);
      n_wr++;
    end
    else if (mem_req.valid && mem_ready)
      n_rd++;
  end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import transfer_controller_pkg::*;
  localparam logic [31:0] BLK = 32'h0001_0100;
  localparam logic [15:0] RMODE [2] = '{16'hA500, 16'hB5A0};
  localparam logic [31:0] RINIT [2] = '{32'h0000_3100, 32'h0000_2100};
  localparam logic [31:0] RSRC [2] = '{32'h0000_2100, 32'h0000_2104};
  localparam logic [31:0] REXP [2] = '{32'h0000_2102, 32'h0000_2100};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic act_valid = 1'b0;
  logic slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [5:0] act_source = 6'h05;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, act_ready, mem_ready, irq_req, xfer_done;
  logic [31:0] hrdata, mem_rdata, rd;
  mem_req_t mem_req;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_irq, n_cyc, rd0, wr0;
  int cyc = 0;
  transfer_controller u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .act_valid(act_valid), .act_source(act_source), .act_ready(act_ready),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .irq_req(irq_req), .xfer_done(xfer_done)
  );
  bus_memory u_mem
  (
    .hclk(hclk), .slow(slow), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata)
  );
  always #5 hclk = ~hclk;
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; read data is taken at the edge that ends the data phase.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wait_done();
    n_irq = 0;
    n_cyc = 0;
    do
    begin
      @(posedge hclk);
      n_irq += int'(irq_req === 1'b1);
      n_cyc++;
    end
    while (xfer_done !== 1'b1);
  endtask
  task automatic fire();
    rd0 = u_mem.n_rd;
    wr0 = u_mem.n_wr;
    act_valid <= 1'b1;
    @(posedge hclk);
    while (act_ready !== 1'b1)
      @(posedge hclk);
    act_valid <= 1'b0;
    wait_done();
  endtask
  task automatic load(input logic [31:0] w0, w1, s, d);
    u_mem.put(BLK, w0, 4);
    u_mem.put(BLK + 32'h4, w1, 4);
    u_mem.put(BLK + 32'h8, s, 4);
    u_mem.put(BLK + 32'hC, d, 4);
  endtask
  task automatic expect_blk(input logic [31:0] w0, w1, s, d);
    chk(u_mem.get(BLK, 4), w0);
    chk(u_mem.get(BLK + 32'h4, 4), w1);
    chk(u_mem.get(BLK + 32'h8, 4), s);
    chk(u_mem.get(BLK + 32'hC, 4), d);
  endtask
  // A hang ends the run as a failure; all tests need well under a thousand cycles.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Registers first, then normal, repeat, block, a software start and a peripheral longword from another source.
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    u_mem.put(32'h0000_040A, 32'h0000_0100, 2);
    u_mem.put(32'h0000_2000, 32'h0000_1122, 2);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0, 32'hABCD_0001);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0000_0001);
    ahb(1'b1, 32'hC, 32'hFFFF_FFFF);
    ahb(1'b0, 32'hC, 32'h0);
    chk(rd, 32'h0);
    load(32'hA000_0002, 32'h5555_AAAA, 32'h0000_2000, 32'h0000_3000);
    fire();
    expect_blk(32'hA000_0001, 32'h5555_AAAA, 32'h0000_2001, 32'h0000_3001);
    chk(u_mem.get(32'h0000_3000, 1), 32'h11);
    chk(32'(u_mem.n_rd - rd0), 32'h6);
    chk(32'(n_irq), 32'h0);
    chk(32'(n_cyc), 32'hB);
    slow <= 1'b1;
    fire();
    expect_blk(32'hA000_0000, 32'h5555_AAAA, 32'h0000_2002, 32'h0000_3002);
    chk(u_mem.get(32'h0000_3001, 1), 32'h22);
    chk(32'(u_mem.n_wr - wr0), 32'h4);
    chk(32'(n_irq), 32'h1);
    slow <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      load({RMODE[k], 16'h0201}, RINIT[k], RSRC[k], 32'h0000_3102);
      fire();
      expect_blk({RMODE[k], 16'h0202}, RINIT[k], REXP[k], 32'h0000_3100);
      chk(32'(n_irq), 32'(k));
    end
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0202_0000);
    slow <= 1'b1;
    for (int i = 0; i < 3; i++)
      u_mem.put(32'h0000_2200 + 4 * i, 32'h1111_1111 * (i + 1), 4);
    load(32'hAA00_0001, 32'hBEEF_0003, 32'h0000_2200, 32'h0000_3200);
    fire();
    expect_blk(32'hAA00_0000, 32'hBEEF_0003, 32'h0000_220C, 32'h0000_3200);
    for (int i = 0; i < 3; i++)
      chk(u_mem.get(32'h0000_3200 + 4 * i, 4), 32'h1111_1111 * (i + 1));
    chk(32'(u_mem.n_rd - rd0), 32'h8);
    chk(32'(u_mem.n_wr - wr0), 32'h6);
    chk(32'(n_irq), 32'h1);
    slow <= 1'b0;
    load(32'h0000_0001, 32'h0, 32'h0000_2000, 32'h0000_3300);
    ahb(1'b1, 32'h4, 32'h0000_010A);
    wait_done();
    expect_blk(32'h0, 32'h0, 32'h0000_2000, 32'h0000_3300);
    chk(u_mem.get(32'h0000_3300, 1), 32'h11);
    chk(32'(n_irq), 32'h1);
    // Another source, and a longword read from a two-state peripheral that must cost four states.
    act_source <= 6'h07;
    u_mem.put(32'h0000_040E, 32'h0000_0100, 2);
    u_mem.put(32'hFFFF_8000, 32'hCAFE_F00D, 4);
    load(32'h2200_0001, 32'h0, 32'hFFFF_8000, 32'h0000_3400);
    fire();
    expect_blk(32'h2200_0000, 32'h0, 32'hFFFF_8000, 32'h0000_3404);
    chk(u_mem.get(32'h0000_3400, 4), 32'hCAFE_F00D);
    chk(32'(n_cyc), 32'hE);
    chk(32'(n_irq), 32'h1);
    give_verdict();
  end
endmodule

// ### testbench/transfer_controller_chk.sv
`timescale 1ns/1ps
module transfer_controller_chk
  import transfer_controller_pkg::*;
#(
  parameter int SRC_W = 6
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [SRC_W-1:0] act_source,
  input wire logic act_ready,
  input wire transfer_controller_pkg::mem_req_t mem_req,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  input wire logic irq_req,
  input wire logic xfer_done
);
  logic [4:0] n;
  logic [31:0] st, w0, vd;
  wire fin = mem_req.valid && mem_ready;
  wire wb = fin && mem_req.write && n > 5'h4;
  wire wb3 = wb && mem_req.addr == st + 32'h0000_000C;
  wire io_addr = mem_req.addr inside {[32'hFFFF_8000:32'hFFFF_87FF]};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Index of completed accesses; it saturates so a long block cannot alias the early slots.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      n <= 5'h0;
      {st, w0, vd} <= 96'h0;
    end
    else
    begin
      n <= (act_ready || xfer_done) ? 5'h0 : n + 5'(fin && n != 5'h1F);
      if (fin && n == 5'h0)
        vd <= mem_rdata;
      if (fin && n == 5'h1)
        {st, w0} <= {mem_req.addr, mem_rdata};
    end
  a_vec_read: assert property (act_ready |=> mem_req.valid && !mem_req.write &&
    mem_req.addr == 32'h0000_0400 + 32'($past(act_source)) * 2) else $error("vector address");
  a_start_low: assert property (fin && n == 5'h1 |-> mem_req.addr[15:0] == vd[15:0])
    else $error("block start");
  a_param_seq: assert property (fin && n inside {[5'h2:5'h4]} |-> !mem_req.write &&
    mem_req.addr == st + 32'(n - 5'h1) * 4) else $error("parameter order");
  a_req_hold: assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
    else $error("request dropped");
  a_unit_size: assert property (mem_req.valid && n == 5'h5 |-> mem_req.size == w0[25:24])
    else $error("unit size");
  a_mode_kept: assert property (wb && mem_req.addr == st |-> mem_req.wdata[31:16] == w0[31:16])
    else $error("mode word");
  a_count_dec: assert property (wb && mem_req.addr == st && w0[27:26] != 2'h1 |->
    mem_req.wdata[15:0] == w0[15:0] - 16'h1) else $error("count");
  a_len_kept: assert property (wb |-> mem_req.addr != st + 32'h0000_0004)
    else $error("length written");
  a_irq_cause: assert property (irq_req |-> $past(wb3)) else $error("stray interrupt");
  a_done_cause: assert property (xfer_done |-> $past(wb3)) else $error("early done");
  a_io_wait: assert property (fin ##1 io_addr |-> !mem_req.valid)
    else $error("peripheral access not delayed");
  c_irq: cover property (irq_req);
  c_quiet: cover property (xfer_done && !irq_req);
  c_stall: cover property (mem_req.valid && !mem_ready);
  c_io_wait: cover property (io_addr && !mem_req.valid);
endmodule

bind transfer_controller transfer_controller_chk #(.SRC_W(SRC_W)) u_chk
(
  .hclk(hclk), .hresetn(hresetn), .act_source(act_source), .act_ready(act_ready), .mem_req(mem_req),
  .mem_ready(mem_ready), .mem_rdata(mem_rdata), .irq_req(irq_req), .xfer_done(xfer_done)
);
